// ### dv/cfd_timers_assertions.sv
`timescale 1ns/1ps
module cfd_timers_assertions #(
  parameter int OLD_BASE_CYC = 5
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic overload_discharge_cond_in,
  input wire logic short_circuit_charge_cond_in,
  input wire logic short_circuit_discharge_first_cond_in,
  input wire logic short_circuit_discharge_second_cond_in,
  input wire logic overload_discharge_fault_out,
  input wire logic short_circuit_charge_fault_out,
  input wire logic short_circuit_discharge_first_fault_out,
  input wire logic short_circuit_discharge_second_fault_out,
  input wire logic [cfd_pkg::NUM_CH-1:0] fault_event_out
);
  localparam int BASE1 = OLD_BASE_CYC + 1;
  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);
  // ----
  // Checks
  // ----
  // Fault timing and clearing
  overload_delay_a: assert property ($rose(overload_discharge_fault_out)
    |-> $past(overload_discharge_cond_in)
    && $past(overload_discharge_cond_in, BASE1)) else $error("early fault");
  charge_delay_a: assert property ($rose(short_circuit_charge_fault_out)
    |-> $past(short_circuit_charge_cond_in)) else $error("early fault");
  overload_clear_a: assert property (!overload_discharge_cond_in
    |=> !overload_discharge_fault_out) else $error("fault not cleared");
  charge_clear_a: assert property (!short_circuit_charge_cond_in
    |=> !short_circuit_charge_fault_out) else $error("fault not cleared");
  overload_hold_a: assert property (overload_discharge_fault_out &&
    overload_discharge_cond_in |=> overload_discharge_fault_out)
    else $error("fault dropped");
  overload_event_a: assert property (fault_event_out[0] ==
    $rose(overload_discharge_fault_out)) else $error("bad event");
  charge_event_a: assert property (fault_event_out[1] ==
    $rose(short_circuit_charge_fault_out)) else $error("bad event");
  short_circuit_discharge_first_clear_a: assert property (!short_circuit_discharge_first_cond_in
    |=> !short_circuit_discharge_first_fault_out)
    else $error("fault not cleared");
  short_circuit_discharge_second_clear_a: assert property (!short_circuit_discharge_second_cond_in
    |=> !short_circuit_discharge_second_fault_out)
    else $error("fault not cleared");
  short_circuit_discharge_first_event_a: assert property (fault_event_out[2] ==
    $rose(short_circuit_discharge_first_fault_out)) else $error("bad event");
  short_circuit_discharge_second_event_a: assert property (fault_event_out[3] ==
    $rose(short_circuit_discharge_second_fault_out)) else $error("bad event");
endmodule // cfd_timers_assertions

bind cfd_fault_delay_timers cfd_timers_assertions #(
  .OLD_BASE_CYC(OLD_BASE_CYC)) chk (.clk_in(clk_in), .rst_in(rst_in),
  .overload_discharge_cond_in(overload_discharge_cond_in),
  .short_circuit_charge_cond_in(short_circuit_charge_cond_in),
  .short_circuit_discharge_first_cond_in(
    short_circuit_discharge_first_cond_in),
  .short_circuit_discharge_second_cond_in(
    short_circuit_discharge_second_cond_in),
  .overload_discharge_fault_out(overload_discharge_fault_out),
  .short_circuit_charge_fault_out(short_circuit_charge_fault_out),
  .short_circuit_discharge_first_fault_out(
    short_circuit_discharge_first_fault_out),
  .short_circuit_discharge_second_fault_out(
    short_circuit_discharge_second_fault_out),
  .fault_event_out(fault_event_out));

// ### dv/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  logic clk_in = 0, rst_in = 1, dbl = 0;
  logic [3:0] cnd = 0, fev, flt;
  logic [3:0] code [4] = '{default: 4'h0};
  int err_count = 0, cmp_count = 0, cyc = 0;
  logic [31:0] expq [$];
  logic [31:0] note;
  // Shortened delay base and steps for simulation, in cycles
  localparam int OB = 5, OS = 10, CS = 3, D1 = 3, D1X = 6, D2 = 2, D2X = 4;
  // ----
  // Bench
  // ----
  cfd_fault_delay_timers #(.OLD_BASE_CYC(OB), .OLD_STEP_CYC(OS),
    .SCC_STEP_CYC(CS), .SHORT_CIRCUIT_DISCHARGE_FIRST_STEP_CYC(D1), .SHORT_CIRCUIT_DISCHARGE_FIRST_STEP_X2_CYC(D1X),
    .SHORT_CIRCUIT_DISCHARGE_SECOND_STEP_CYC(D2), .SHORT_CIRCUIT_DISCHARGE_SECOND_STEP_X2_CYC(D2X)) DUT (.clk_in(clk_in),
    .rst_in(rst_in), .discharge_short_delay_doubler_in(dbl),
    .overload_discharge_cond_in(cnd[0]), .short_circuit_charge_cond_in(cnd[1]),
    .short_circuit_discharge_first_cond_in(cnd[2]),
    .short_circuit_discharge_second_cond_in(cnd[3]),
    .overload_discharge_code_in(code[0]), .short_circuit_charge_code_in(code[1]),
    .short_circuit_discharge_first_code_in(code[2]),
    .short_circuit_discharge_second_code_in(code[3]),
    .overload_discharge_fault_out(flt[0]),
    .short_circuit_charge_fault_out(flt[1]),
    .short_circuit_discharge_first_fault_out(flt[2]),
    .short_circuit_discharge_second_fault_out(flt[3]),
    .fault_event_out(fev));
  // Clock and cycle count
  initial forever #2 clk_in = ~clk_in;
  always @(posedge clk_in) cyc <= cyc + 1;
  // Compare each event against the oldest note
  always @(negedge clk_in) if (fev !== 4'h0) begin
    note = expq.size() ? expq.pop_front() : 32'hx;
    check(note, {fev, 28'(cyc)});
    check({28'h0, note[31:28]}, {28'h0, flt});
  end
  task automatic check(logic [31:0] e, logic [31:0] g);
    cmp_count++;
    if (e !== g) begin
      err_count++;
      $display("ERROR t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask
  task automatic give_verdict;
    $display("compares %0d errors %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // Short pulse one cycle too brief when the delay is nonzero, then a held condition
  task automatic run(int ch, logic [3:0] c, logic d);
    int t;
    t = ch == 0 ? OB + OS * c : ch == 1 ? CS * c :
      ch == 2 ? (d ? D1X : D1) * c : (d ? D2X : D2) * c;
    code[ch] = c;
    dbl = d;
    if (t > 0) begin
      cnd[ch] = 1;
      repeat (t) @(negedge clk_in);
      cnd[ch] = 0;
      @(negedge clk_in);
    end
    cnd[ch] = 1;
    expq.push_back({4'h1 << ch, 28'(cyc + 1 + t)});
    for (int i = 0; i < 300 && expq.size() > 0; i++) @(negedge clk_in);
    if (expq.size() > 0) begin
      err_count++;
      give_verdict;
    end
    cnd[ch] = 0;
    repeat (2) @(negedge clk_in);
    check(32'h0, {28'h0, flt});
  endtask
  // Reset, then every channel at longest, zero and random codes
  initial begin
    void'($urandom(32'h3f12));
    repeat (4) @(negedge clk_in);
    rst_in = 0;
    for (int i = 0; i < 16; i++) begin
      run(i % 4, i < 4 ? 4'hf : i < 8 ? 4'h0 : 4'($urandom), 1'($urandom));
    end
    give_verdict;
  end
endmodule // tb_top

// ### src/cfd_fault_delay_timers.sv
`timescale 1ns/1ps
module cfd_fault_delay_timers #(
  parameter int CODE_W = cfd_pkg::CODE_W,
  parameter int CNT_W = cfd_pkg::CNT_W,
  parameter int OLD_BASE_CYC = cfd_pkg::OLD_BASE_CYC,
  parameter int OLD_STEP_CYC = cfd_pkg::OLD_STEP_CYC,
  parameter int SCC_STEP_CYC = cfd_pkg::SCC_STEP_CYC,
  parameter int SHORT_CIRCUIT_DISCHARGE_FIRST_STEP_CYC = cfd_pkg::SHORT_CIRCUIT_DISCHARGE_FIRST_STEP_CYC,
  parameter int SHORT_CIRCUIT_DISCHARGE_FIRST_STEP_X2_CYC = cfd_pkg::SHORT_CIRCUIT_DISCHARGE_FIRST_STEP_X2_CYC,
  parameter int SHORT_CIRCUIT_DISCHARGE_SECOND_STEP_CYC = cfd_pkg::SHORT_CIRCUIT_DISCHARGE_SECOND_STEP_CYC,
  parameter int SHORT_CIRCUIT_DISCHARGE_SECOND_STEP_X2_CYC = cfd_pkg::SHORT_CIRCUIT_DISCHARGE_SECOND_STEP_X2_CYC
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // Comparator levels
  input wire logic overload_discharge_cond_in,
  input wire logic short_circuit_charge_cond_in,
  input wire logic short_circuit_discharge_first_cond_in,
  input wire logic short_circuit_discharge_second_cond_in,
  // Delay codes
  input wire logic [CODE_W-1:0] overload_discharge_code_in,
  input wire logic [CODE_W-1:0] short_circuit_charge_code_in,
  input wire logic [CODE_W-1:0] short_circuit_discharge_first_code_in,
  input wire logic [CODE_W-1:0] short_circuit_discharge_second_code_in,
  // Range doubler for both discharge short detectors
  input wire logic discharge_short_delay_doubler_in,
  // Fault levels and first-declaration pulses
  output logic overload_discharge_fault_out,
  output logic short_circuit_charge_fault_out,
  output logic short_circuit_discharge_first_fault_out,
  output logic short_circuit_discharge_second_fault_out,
  output logic [cfd_pkg::NUM_CH-1:0] fault_event_out
);

  // ----------------------------------------------------------------
  // Channel wiring
  // ----------------------------------------------------------------
  logic [cfd_pkg::NUM_CH-1:0] cond;
  logic [cfd_pkg::NUM_CH-1:0][CNT_W-1:0] target;
  logic [cfd_pkg::NUM_CH-1:0] fault;
  logic [cfd_pkg::NUM_CH-1:0] event_pulse;
  logic [CNT_W-1:0] short_circuit_discharge_first_step;
  logic [CNT_W-1:0] short_circuit_discharge_second_step;
  localparam logic [CNT_W-1:0] NO_BASE = '0;

  // ----------------------------------------------------------------
  // Delay targets per channel
  // ----------------------------------------------------------------
  // Comparator levels gathered by channel index
  assign cond[cfd_pkg::CH_OLD] = overload_discharge_cond_in;
  assign cond[cfd_pkg::CH_SCC] = short_circuit_charge_cond_in;
  assign cond[cfd_pkg::CH_SHORT_CIRCUIT_DISCHARGE_FIRST] = short_circuit_discharge_first_cond_in;
  assign cond[cfd_pkg::CH_SHORT_CIRCUIT_DISCHARGE_SECOND] = short_circuit_discharge_second_cond_in;

  // Doubler widens both discharge short-circuit steps
  assign short_circuit_discharge_first_step = discharge_short_delay_doubler_in ?
    CNT_W'(SHORT_CIRCUIT_DISCHARGE_FIRST_STEP_X2_CYC) : CNT_W'(SHORT_CIRCUIT_DISCHARGE_FIRST_STEP_CYC);
  assign short_circuit_discharge_second_step = discharge_short_delay_doubler_in ?
    CNT_W'(SHORT_CIRCUIT_DISCHARGE_SECOND_STEP_X2_CYC) : CNT_W'(SHORT_CIRCUIT_DISCHARGE_SECOND_STEP_CYC);

  // One target per channel: base plus code times step
  cfd_delay_target #(
    .CODE_W(CODE_W),
    .CNT_W(CNT_W)
  ) u_old_target (
    .base_in(CNT_W'(OLD_BASE_CYC)),
    .step_in(CNT_W'(OLD_STEP_CYC)),
    .code_in(overload_discharge_code_in),
    .target_out(target[cfd_pkg::CH_OLD])
  );

  cfd_delay_target #(
    .CODE_W(CODE_W),
    .CNT_W(CNT_W)
  ) u_scc_target (
    .base_in(NO_BASE),
    .step_in(CNT_W'(SCC_STEP_CYC)),
    .code_in(short_circuit_charge_code_in),
    .target_out(target[cfd_pkg::CH_SCC])
  );

  cfd_delay_target #(
    .CODE_W(CODE_W),
    .CNT_W(CNT_W)
  ) u_short_circuit_discharge_first_target (
    .base_in(NO_BASE),
    .step_in(short_circuit_discharge_first_step),
    .code_in(short_circuit_discharge_first_code_in),
    .target_out(target[cfd_pkg::CH_SHORT_CIRCUIT_DISCHARGE_FIRST])
  );

  cfd_delay_target #(
    .CODE_W(CODE_W),
    .CNT_W(CNT_W)
  ) u_short_circuit_discharge_second_target (
    .base_in(NO_BASE),
    .step_in(short_circuit_discharge_second_step),
    .code_in(short_circuit_discharge_second_code_in),
    .target_out(target[cfd_pkg::CH_SHORT_CIRCUIT_DISCHARGE_SECOND])
  );

  // ----------------------------------------------------------------
  // Persistence counters
  // ----------------------------------------------------------------
  // One persistence timer per channel, all alike
  for (genvar i = 0; i < cfd_pkg::NUM_CH; i++) begin : g_chan
    cfd_persist_channel #(
      .CNT_W(CNT_W)
    ) u_chan (
      .clk_in(clk_in),
      .rst_in(rst_in),
      .cond_in(cond[i]),
      .target_in(target[i]),
      .fault_out(fault[i]),
      .event_out(event_pulse[i])
    );
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // Fault levels and first-declaration pulses straight from flops
  assign overload_discharge_fault_out = fault[cfd_pkg::CH_OLD];
  assign short_circuit_charge_fault_out = fault[cfd_pkg::CH_SCC];
  assign short_circuit_discharge_first_fault_out =
    fault[cfd_pkg::CH_SHORT_CIRCUIT_DISCHARGE_FIRST];
  assign short_circuit_discharge_second_fault_out =
    fault[cfd_pkg::CH_SHORT_CIRCUIT_DISCHARGE_SECOND];
  assign fault_event_out = event_pulse;

endmodule // cfd_fault_delay_timers

// ----------------------------------------------------------------
// Persistence timer for one channel
// ----------------------------------------------------------------
module cfd_persist_channel #(
  parameter int CNT_W = cfd_pkg::CNT_W
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic cond_in,
  input wire logic [CNT_W-1:0] target_in,
  output logic fault_out,
  output logic event_out
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [CNT_W-1:0] cnt;
    logic fault;
    logic event_pulse;
  } cfd_chan_state_t;

  cfd_chan_state_t state;
  cfd_chan_state_t next_state;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  // Count while tripped, declare at target, restart when clear
  always_comb begin
    next_state = state;
    next_state.event_pulse = 1'b0;
    if (!cond_in) begin
      next_state.cnt = CNT_W'(cfd_pkg::CNT_RESET);
      next_state.fault = 1'b0;
    end else if (state.cnt >= target_in) begin
      next_state.fault = 1'b1;
      next_state.event_pulse = !state.fault;
    end else begin
      next_state.cnt = state.cnt + 1'b1;
    end
  end

  // State register, counter held at target once declared
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      state.cnt <= CNT_W'(cfd_pkg::CNT_RESET);
      state.fault <= 1'b0;
      state.event_pulse <= 1'b0;
    end else begin
      state <= next_state;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // Level and pulse straight from flops
  assign fault_out = state.fault;
  assign event_out = state.event_pulse;

endmodule // cfd_persist_channel

// ----------------------------------------------------------------
// Delay target for one channel
// ----------------------------------------------------------------
module cfd_delay_target #(
  parameter int CODE_W = cfd_pkg::CODE_W,
  parameter int CNT_W = cfd_pkg::CNT_W
) (
  input wire logic [CNT_W-1:0] base_in,
  input wire logic [CNT_W-1:0] step_in,
  input wire logic [CODE_W-1:0] code_in,
  output logic [CNT_W-1:0] target_out
);

  // Base plus code times step, cut to counter width
  assign target_out =
    CNT_W'(int'(base_in) + int'(code_in) * int'(step_in));

endmodule // cfd_delay_target

// ### src/cfd_pkg.sv
package cfd_pkg;

  // ----------------------------------------------------------------
  // Clock
  // ----------------------------------------------------------------
  localparam real CLK_PERIOD_NS = 4.0;

  // ----------------------------------------------------------------
  // Delay times, in their own units
  // ----------------------------------------------------------------
  localparam real OLD_BASE_MS = 1.0;
  localparam real OLD_STEP_MS = 2.0;
  localparam real SCC_STEP_US = 61.0;
  localparam real SHORT_CIRCUIT_DISCHARGE_FIRST_STEP_US = 61.0;
  localparam real SHORT_CIRCUIT_DISCHARGE_FIRST_STEP_X2_US = 121.0;
  localparam real SHORT_CIRCUIT_DISCHARGE_SECOND_STEP_US = 30.5;
  localparam real SHORT_CIRCUIT_DISCHARGE_SECOND_STEP_X2_US = 61.0;
  localparam real DETECT_MAX_US = 160.0;

  // ----------------------------------------------------------------
  // Delay times as clock cycles (nominal steps, truncated)
  // ----------------------------------------------------------------
  localparam int OLD_BASE_CYC = $rtoi(OLD_BASE_MS * 1.0e6 / CLK_PERIOD_NS);
  localparam int OLD_STEP_CYC = $rtoi(OLD_STEP_MS * 1.0e6 / CLK_PERIOD_NS);
  localparam int SCC_STEP_CYC = $rtoi(SCC_STEP_US * 1.0e3 / CLK_PERIOD_NS);
  localparam int SHORT_CIRCUIT_DISCHARGE_FIRST_STEP_CYC = $rtoi(SHORT_CIRCUIT_DISCHARGE_FIRST_STEP_US * 1.0e3 / CLK_PERIOD_NS);
  localparam int SHORT_CIRCUIT_DISCHARGE_FIRST_STEP_X2_CYC =
    $rtoi(SHORT_CIRCUIT_DISCHARGE_FIRST_STEP_X2_US * 1.0e3 / CLK_PERIOD_NS);
  localparam int SHORT_CIRCUIT_DISCHARGE_SECOND_STEP_CYC = $rtoi(SHORT_CIRCUIT_DISCHARGE_SECOND_STEP_US * 1.0e3 / CLK_PERIOD_NS);
  localparam int SHORT_CIRCUIT_DISCHARGE_SECOND_STEP_X2_CYC =
    $rtoi(SHORT_CIRCUIT_DISCHARGE_SECOND_STEP_X2_US * 1.0e3 / CLK_PERIOD_NS);
  localparam int DETECT_MAX_CYC =
    $rtoi(DETECT_MAX_US * 1.0e3 / CLK_PERIOD_NS);

  // ----------------------------------------------------------------
  // Widths, channel indices, reset values
  // ----------------------------------------------------------------
  localparam int CODE_W = 4;
  localparam int CNT_W = 24;
  localparam int NUM_CH = 4;
  localparam int CH_OLD = 0;
  localparam int CH_SCC = 1;
  localparam int CH_SHORT_CIRCUIT_DISCHARGE_FIRST = 2;
  localparam int CH_SHORT_CIRCUIT_DISCHARGE_SECOND = 3;
  localparam logic [CNT_W-1:0] CNT_RESET = 24'h000000;
  localparam logic [NUM_CH-1:0] FLAG_RESET = 4'h0;

endpackage
